// File: cc_match_regs.vh
// Offsets, field positions, reset values and timing for the line match status bank
`ifndef CC_MATCH_REGS_VH
`define CC_MATCH_REGS_VH
// Register offsets
`define ADDR_LINE_EVENT_STATUS 12'h803
`define ADDR_LINE1_CHANGE_FLAGS 12'h804
`define ADDR_LINE2_CHANGE_FLAGS 12'h805
`define ADDR_LINE1_THRESHOLD_MATCH 12'h806
`define ADDR_LINE2_THRESHOLD_MATCH 12'h807
// Event register bit positions
`define EVT_FIRST_MATCH_VALID 7
`define EVT_ADVERT_CHANGED 6
`define EVT_DETACH 5
`define EVT_ATTACH 4
`define EVT_LINE2_SUMMARY 1
`define EVT_LINE1_SUMMARY 0
// Reset values
`define CHANGE_FLAGS_RESET 8'h00
`define MATCH_RESET_DOWNSTREAM 8'hFF
`define MATCH_RESET_UPSTREAM 8'h00
// Role encoding of the device role bit
`define ROLE_UPSTREAM 1'b0
`define ROLE_DOWNSTREAM 1'b1
// Port attach state encoding
`define PORT_UNATTACHED 2'h0
`define PORT_ATTACH_WAIT 2'h1
`define PORT_ATTACHED 2'h2
// Timing
`define CLK_PERIOD_NS 50
`define UNIT_SHORT_NS 100000
`define UNIT_LONG_NS 1600000
`define UNIT_SHORT_CYCLES (`UNIT_SHORT_NS / `CLK_PERIOD_NS)
`define UNIT_LONG_CYCLES (`UNIT_LONG_NS / `CLK_PERIOD_NS)
`endif

// File: line_debounce.v
// Per-line threshold match debouncer with raw/debounced selection
`timescale 1ns/10ps
`default_nettype none
`include "cc_match_regs.vh"
module line_debounce #(
    parameter WIDTH = 8  // Thresholds per line
) (
    input wire clk_sys_in,  // System clock
    input wire rst_in,  // Async reset, high
    input wire [WIDTH-1:0] raw_in,  // Raw comparator results
    input wire hold_in,  // Force reset value
    input wire [WIDTH-1:0] default_in,  // Role-based reset value
    input wire [1:0] port_state_in,  // Attach state
    input wire open_line_in,  // Open-line condition seen
    input wire unatt_tick_in,  // Unattached time base pulse
    input wire att_tick_in,  // Attached time base pulse
    input wire [7:0] unatt_time_in,  // Unattached interval in units
    input wire [7:0] att_time_in,  // Attached interval in units
    input wire [WIDTH-1:0] dbclr_en_in,  // 1 selects debounced bit
    output wire [WIDTH-1:0] match_out,  // Visible match value
    output wire first_valid_out  // Pulse on first valid match
);
    reg [WIDTH-1:0] raw_prev_q;  // Raw value last cycle
    reg [WIDTH-1:0] deb_q;  // Debounced value
    reg [7:0] cnt_q;  // Stable-time counter
    reg loaded_q;  // Reset value applied once
    reg valid_q;  // A match has become valid
    wire unatt;  // In unattached state
    wire wait_st;  // In attach-wait state
    wire tick;  // Selected time base
    wire [7:0] limit;  // Selected interval
    wire stable;  // Raw unchanged
    wire reached;  // Interval expired

    assign unatt = (port_state_in == `PORT_UNATTACHED);
    assign wait_st = (port_state_in == `PORT_ATTACH_WAIT);
    assign tick = unatt ? unatt_tick_in : att_tick_in;
    assign limit = unatt ? unatt_time_in : att_time_in;
    assign stable = (raw_in == raw_prev_q);
    assign reached = stable && (cnt_q == limit) && (!wait_st || open_line_in);
    assign match_out = hold_in ? default_in : ((deb_q & dbclr_en_in) | (raw_in & ~dbclr_en_in));
    assign first_valid_out = reached && !valid_q && !hold_in;

    // Debounce counter and value update
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            raw_prev_q <= {WIDTH{1'b0}};
            deb_q <= {WIDTH{1'b0}};
            cnt_q <= 8'h00;
            loaded_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            raw_prev_q <= raw_in;
            if (!loaded_q || hold_in) begin
                deb_q <= default_in;
                loaded_q <= 1'b1;
                valid_q <= 1'b0;
                cnt_q <= 8'h00;
            end else if (!stable || (wait_st && !open_line_in)) begin
                // Restart on any movement
                cnt_q <= 8'h00;
            end else if (reached) begin
                deb_q <= raw_in;
                valid_q <= 1'b1;
            end else if (tick) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule // line_debounce
`default_nettype wire

// File: attach_detect.v
// Attach, detach and current advertisement change pulse sources
`timescale 1ns/10ps
`default_nettype none
`include "cc_match_regs.vh"
module attach_detect (
    input wire clk_sys_in,  // System clock
    input wire rst_in,  // Async reset, high
    input wire role_in,  // 1 downstream, 0 upstream
    input wire line_present_in,  // Line comparators see partner
    input wire vbus_present_in,  // VBUS present
    input wire [1:0] advert_in,  // Partner current advertisement
    output wire attach_out,  // Attach pulse
    output wire detach_out,  // Detach pulse
    output wire advert_chg_out,  // Advertisement change pulse
    output wire [1:0] advert_out  // Latched advertisement
);
    reg att_q;  // Attach condition last cycle
    reg det_q;  // Detach watch signal last cycle
    reg [1:0] adv_q;  // Advertisement last cycle
    reg primed_q;  // History valid after reset
    wire att_lvl;  // Attach condition
    wire det_lvl;  // Signal watched for detach

    assign att_lvl = (role_in == `ROLE_DOWNSTREAM) ? line_present_in
                     : (line_present_in && vbus_present_in);
    assign det_lvl = (role_in == `ROLE_DOWNSTREAM) ? line_present_in : vbus_present_in;
    assign attach_out = primed_q && att_lvl && !att_q;
    assign detach_out = primed_q && !det_lvl && det_q;
    assign advert_chg_out = primed_q && (advert_in != adv_q);
    assign advert_out = adv_q;

    // Edge history
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            att_q <= 1'b0;
            det_q <= 1'b0;
            adv_q <= 2'h0;
            primed_q <= 1'b0;
        end else begin
            att_q <= att_lvl;
            det_q <= det_lvl;
            adv_q <= advert_in;
            primed_q <= 1'b1;
        end
    end
endmodule // attach_detect
`default_nettype wire

// File: cc_threshold_match_status.v
// Line threshold match, change flag and event status register bank
`timescale 1ns/10ps
`default_nettype none
`include "cc_match_regs.vh"
module cc_threshold_match_status #(
    parameter WIDTH = 8,  // Thresholds per line
    parameter UNIT_LONG_CYCLES = `UNIT_LONG_CYCLES,  // Cycles per 1.6 ms unit
    parameter UNIT_SHORT_CYCLES = `UNIT_SHORT_CYCLES  // Cycles per 100 us unit
) (
    input wire clk_sys_in,  // 20 MHz system clock
    input wire rst_in,  // Async reset, high
    input wire [11:0] reg_addr_in,  // Register address
    input wire reg_wr_in,  // Write strobe
    input wire reg_rd_in,  // Read strobe
    input wire [15:0] reg_wdata_in,  // Write data
    output reg [15:0] reg_rdata_out,  // Read data, held
    input wire [WIDTH-1:0] line1_raw_in,  // Line 1 comparator results
    input wire [WIDTH-1:0] line2_raw_in,  // Line 2 comparator results
    input wire [WIDTH-1:0] line1_dbclr_en_in,  // Line 1 debounce clear enable
    input wire [WIDTH-1:0] line2_dbclr_en_in,  // Line 2 debounce clear enable
    input wire comparator_enable_in,  // Line comparator enabled
    input wire standalone_in,  // Standalone operation
    input wire device_role_in,  // 0 upstream, 1 downstream
    input wire debounce_unit_select_in,  // 0 1.6 ms, 1 100 us
    input wire [7:0] unattached_debounce_time_in,  // Unattached interval units
    input wire [7:0] attached_debounce_time_in,  // Attached interval, 100 us units
    input wire [1:0] port_state_in,  // Attach state
    input wire open_line_in,  // Open-line condition seen
    input wire line_present_in,  // Partner seen on lines
    input wire vbus_present_in,  // VBUS present
    input wire [1:0] advert_in,  // Partner current advertisement
    output reg [1:0] current_advert_out,  // Advertisement for line control
    output reg [WIDTH-1:0] line1_match_out,  // Line 1 match value
    output reg [WIDTH-1:0] line2_match_out  // Line 2 match value
);
    // Time base counters
    reg [15:0] short_cnt_q;  // 100 us divider
    reg [15:0] long_cnt_q;  // 1.6 ms divider
    reg short_tick_q;  // 100 us pulse
    reg long_tick_q;  // 1.6 ms pulse
    // Status registers
    reg [WIDTH-1:0] flags1_q;  // Line 1 change flags
    reg [WIDTH-1:0] flags2_q;  // Line 2 change flags
    reg [WIDTH-1:0] prev1_q;  // Line 1 match last cycle
    reg [WIDTH-1:0] prev2_q;  // Line 2 match last cycle
    reg primed_q;  // Match history valid
    reg fmv_q;  // First match valid flag
    reg fmv_done_q;  // First match already reported
    reg adv_chg_q;  // Advertisement changed flag
    reg detach_q;  // Detach flag
    reg attach_q;  // Attach flag
    // Next values
    reg [WIDTH-1:0] flags1_d;  // Next line 1 flags
    reg [WIDTH-1:0] flags2_d;  // Next line 2 flags
    reg fmv_d;  // Next first match valid
    reg adv_chg_d;  // Next advert changed
    reg detach_d;  // Next detach
    reg attach_d;  // Next attach
    reg [15:0] rdata_d;  // Next read data
    // Internal nets
    wire hold;  // Match held at default
    wire sa_up;  // Standalone upstream role
    wire [WIDTH-1:0] dflt;  // Role-based match default
    wire unatt_tick;  // Unattached time base
    wire [WIDTH-1:0] m1;  // Line 1 visible match
    wire [WIDTH-1:0] m2;  // Line 2 visible match
    wire fv1;  // Line 1 first valid pulse
    wire fv2;  // Line 2 first valid pulse
    wire att_p;  // Attach pulse
    wire det_p;  // Detach pulse
    wire adv_p;  // Advert change pulse
    wire [1:0] adv_lvl;  // Latched advertisement
    wire wr_evt;  // Write to event register
    wire wr_f1;  // Write to line 1 flags
    wire wr_f2;  // Write to line 2 flags
    wire [15:0] evt;  // Event register image

    // Sticky flag with write-1 clear
    function sticky;
        input cur;  // Current flag
        input set;  // Set event
        input clr;  // Clear request
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    assign hold = !standalone_in && !comparator_enable_in;
    assign sa_up = standalone_in && (device_role_in == `ROLE_UPSTREAM);
    assign dflt = (device_role_in == `ROLE_DOWNSTREAM) ? `MATCH_RESET_DOWNSTREAM
                  : `MATCH_RESET_UPSTREAM;
    assign unatt_tick = debounce_unit_select_in ? short_tick_q : long_tick_q;

    assign wr_evt = reg_wr_in && (reg_addr_in == `ADDR_LINE_EVENT_STATUS);
    assign wr_f1 = reg_wr_in && (reg_addr_in == `ADDR_LINE1_CHANGE_FLAGS);
    assign wr_f2 = reg_wr_in && (reg_addr_in == `ADDR_LINE2_CHANGE_FLAGS);

    // Line 1 debouncer
    line_debounce #(
        .WIDTH(WIDTH)
    ) u_deb1 (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .raw_in(line1_raw_in),
        .hold_in(hold),
        .default_in(dflt),
        .port_state_in(port_state_in),
        .open_line_in(open_line_in),
        .unatt_tick_in(unatt_tick),
        .att_tick_in(short_tick_q),
        .unatt_time_in(unattached_debounce_time_in),
        .att_time_in(attached_debounce_time_in),
        .dbclr_en_in(line1_dbclr_en_in),
        .match_out(m1),
        .first_valid_out(fv1)
    );

    // Line 2 debouncer
    line_debounce #(
        .WIDTH(WIDTH)
    ) u_deb2 (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .raw_in(line2_raw_in),
        .hold_in(hold),
        .default_in(dflt),
        .port_state_in(port_state_in),
        .open_line_in(open_line_in),
        .unatt_tick_in(unatt_tick),
        .att_tick_in(short_tick_q),
        .unatt_time_in(unattached_debounce_time_in),
        .att_time_in(attached_debounce_time_in),
        .dbclr_en_in(line2_dbclr_en_in),
        .match_out(m2),
        .first_valid_out(fv2)
    );

    // Attach, detach and advertisement sources
    attach_detect u_attach (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .role_in(device_role_in),
        .line_present_in(line_present_in),
        .vbus_present_in(vbus_present_in),
        .advert_in(advert_in),
        .attach_out(att_p),
        .detach_out(det_p),
        .advert_chg_out(adv_p),
        .advert_out(adv_lvl)
    );

    // Event register image, reserved bits zero
    // Summary of change flags
    // Bit 6 reads zero off role
    assign evt = {8'h00, fmv_q, adv_chg_q & sa_up, detach_q, attach_q, 2'b00,
                  (|flags2_q), (|flags1_q)};

    // Time base dividers
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            short_cnt_q <= 16'h0000;
            long_cnt_q <= 16'h0000;
            short_tick_q <= 1'b0;
            long_tick_q <= 1'b0;
        end else begin
            short_tick_q <= (short_cnt_q == UNIT_SHORT_CYCLES[15:0] - 16'h0001);
            long_tick_q <= (long_cnt_q == UNIT_LONG_CYCLES[15:0] - 16'h0001);
            if (short_cnt_q == UNIT_SHORT_CYCLES[15:0] - 16'h0001) begin
                short_cnt_q <= 16'h0000;
            end else begin
                short_cnt_q <= short_cnt_q + 16'h0001;
            end
            if (long_cnt_q == UNIT_LONG_CYCLES[15:0] - 16'h0001) begin
                long_cnt_q <= 16'h0000;
            end else begin
                long_cnt_q <= long_cnt_q + 16'h0001;
            end
        end
    end

    // Next state of flags and read data
    always @* begin
        flags1_d = ({WIDTH{primed_q}} & (m1 ^ prev1_q))
                   | (flags1_q & ~({WIDTH{wr_f1}} & reg_wdata_in[WIDTH-1:0]));
        flags2_d = ({WIDTH{primed_q}} & (m2 ^ prev2_q))
                   | (flags2_q & ~({WIDTH{wr_f2}} & reg_wdata_in[WIDTH-1:0]));
        fmv_d = sticky(fmv_q, (fv1 | fv2) & ~fmv_done_q,
                       wr_evt & reg_wdata_in[`EVT_FIRST_MATCH_VALID]);
        adv_chg_d = sticky(adv_chg_q, adv_p & sa_up,
                           wr_evt & reg_wdata_in[`EVT_ADVERT_CHANGED]);
        if (!sa_up) begin
            adv_chg_d = 1'b0;
        end
        detach_d = sticky(detach_q, det_p & standalone_in,
                          wr_evt & reg_wdata_in[`EVT_DETACH]);
        attach_d = sticky(attach_q, att_p & standalone_in,
                          wr_evt & reg_wdata_in[`EVT_ATTACH]);
        // Read decode, unmapped reads zero
        case (reg_addr_in)
            `ADDR_LINE_EVENT_STATUS: begin
                rdata_d = evt;
            end
            `ADDR_LINE1_CHANGE_FLAGS: begin
                rdata_d = {{(16-WIDTH){1'b0}}, flags1_q};
            end
            `ADDR_LINE2_CHANGE_FLAGS: begin
                rdata_d = {{(16-WIDTH){1'b0}}, flags2_q};
            end
            `ADDR_LINE1_THRESHOLD_MATCH: begin
                rdata_d = {{(16-WIDTH){1'b0}}, m1};
            end
            `ADDR_LINE2_THRESHOLD_MATCH: begin
                rdata_d = {{(16-WIDTH){1'b0}}, m2};
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // Status and output registers
    always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            flags1_q <= `CHANGE_FLAGS_RESET;
            flags2_q <= `CHANGE_FLAGS_RESET;
            prev1_q <= {WIDTH{1'b0}};
            prev2_q <= {WIDTH{1'b0}};
            primed_q <= 1'b0;
            fmv_q <= 1'b0;
            fmv_done_q <= 1'b0;
            adv_chg_q <= 1'b0;
            detach_q <= 1'b0;
            attach_q <= 1'b0;
            reg_rdata_out <= 16'h0000;
            current_advert_out <= 2'h0;
            line1_match_out <= {WIDTH{1'b0}};
            line2_match_out <= {WIDTH{1'b0}};
        end else begin
            flags1_q <= flags1_d;
            flags2_q <= flags2_d;
            prev1_q <= m1;
            prev2_q <= m2;
            // History valid once defaults loaded
            primed_q <= 1'b1;
            fmv_q <= fmv_d;
            // Report only the very first match
            if (fv1 | fv2) begin
                fmv_done_q <= 1'b1;
            end
            adv_chg_q <= adv_chg_d;
            detach_q <= detach_d;
            attach_q <= attach_d;
            // Read data held until next read
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_d;
            end
            if (sa_up) begin
                current_advert_out <= adv_lvl;
            end
            line1_match_out <= m1;
            line2_match_out <= m2;
        end
    end
endmodule // cc_threshold_match_status
`default_nettype wire

// File: cc_status_checker_properties.sv
// Port checker for the line match status bank
`timescale 1ns/10ps
`default_nettype none
module cc_status_checker (
    input wire logic clk_sys_in,  // Clock
    input wire logic rst_in,  // Reset
    input wire logic [11:0] reg_addr_in,  // Address
    input wire logic reg_wr_in,  // Write strobe
    input wire logic reg_rd_in,  // Read strobe
    input wire logic [15:0] reg_wdata_in,  // Write data
    input wire logic [15:0] reg_rdata_out,  // Read data
    input wire logic [7:0] line1_match_out,  // Line 1 match
    input wire logic [7:0] line2_match_out,  // Line 2 match
    input wire logic [7:0] line2_raw_in,  // Line 2 raw
    input wire logic [7:0] line2_dbclr_en_in,  // Line 2 debounce select
    input wire logic comparator_enable_in,  // Comparator on
    input wire logic standalone_in,  // Standalone
    input wire logic device_role_in,  // Role
    input wire logic [1:0] advert_in,  // Advertisement in
    input wire logic [1:0] current_advert_out  // Advertisement out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic rd_evt;  // Event register read
    logic hold;  // Match forced to role default
    assign rd_evt = reg_rd_in && reg_addr_in == 12'h803;
    assign hold = !standalone_in && !comparator_enable_in;
    property p_evt_reserved;
        rd_evt |=> reg_rdata_out[15:8] == 8'h00 && reg_rdata_out[3:2] == 2'h0;
    endproperty
    a_evt_reserved: assert property (p_evt_reserved)
        else $error("event register reserved bits not zero");
    property p_advert_zero;
        rd_evt && !(standalone_in && !device_role_in) |=> !reg_rdata_out[6];
    endproperty
    a_advert_zero: assert property (p_advert_zero)
        else $error("advert change bit set outside standalone upstream");
    property p_hold_line1;
        (hold && $stable(device_role_in))[*4] |-> line1_match_out == (device_role_in ? 8'hFF : 8'h00);
    endproperty
    a_hold_line1: assert property (p_hold_line1)
        else $error("line 1 match not at role default");
    property p_hold_line2;
        (hold && $stable(device_role_in))[*4] |-> line2_match_out == (device_role_in ? 8'hFF : 8'h00);
    endproperty
    a_hold_line2: assert property (p_hold_line2)
        else $error("line 2 match not at role default");
    property p_raw_line2;
        (comparator_enable_in && line2_dbclr_en_in == 8'h00 && $stable(line2_raw_in))[*3]
            |-> line2_match_out == line2_raw_in;
    endproperty
    a_raw_line2: assert property (p_raw_line2)
        else $error("line 2 raw mode not showing comparator");
    property p_flag_clear;
        (reg_wr_in && reg_addr_in == 12'h804 && reg_wdata_in[7:0] == 8'hFF) ##1 $stable(line1_match_out)
            ##1 (reg_rd_in && reg_addr_in == 12'h804 && $stable(line1_match_out))
            |=> reg_rdata_out == 16'h0000;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("line 1 change flags not cleared");
    property p_advert_follow;
        (standalone_in && !device_role_in && $stable(advert_in))[*4] |-> current_advert_out == advert_in;
    endproperty
    a_advert_follow: assert property (p_advert_follow)
        else $error("current advertisement not updated");
    property p_match_read;
        (reg_rd_in && reg_addr_in == 12'h806) ##1 $stable(line1_match_out)
            |-> reg_rdata_out == {8'h00, line1_match_out};
    endproperty
    a_match_read: assert property (p_match_read)
        else $error("line 1 match read differs from port");
    cover property (reg_wr_in && reg_addr_in == 12'h804);
    cover property (standalone_in && !device_role_in && $changed(current_advert_out));
    cover property (comparator_enable_in && $changed(line1_match_out));
endmodule // cc_status_checker
bind cc_threshold_match_status cc_status_checker u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .line1_match_out(line1_match_out),
    .line2_match_out(line2_match_out), .line2_raw_in(line2_raw_in),
    .line2_dbclr_en_in(line2_dbclr_en_in), .comparator_enable_in(comparator_enable_in),
    .standalone_in(standalone_in), .device_role_in(device_role_in), .advert_in(advert_in),
    .current_advert_out(current_advert_out));
`default_nettype wire

// File: cc_far_side.sv
// Comparator and port partner model driving the line inputs
`timescale 1ns/10ps
`default_nettype none
module cc_far_side (
    input wire logic clk_sys_in,  // Clock
    input wire logic [7:0] lvl1_in,  // Line 1 levels above thresholds
    input wire logic [7:0] lvl2_in,  // Line 2 levels above thresholds
    input wire logic present_in,  // Partner on lines
    input wire logic vbus_in,  // VBUS supplied
    input wire logic [1:0] advert_in,  // Current advertised
    input wire logic slow_in,  // Extra settling stage
    output logic [7:0] line1_raw_out,  // Line 1 comparators
    output logic [7:0] line2_raw_out,  // Line 2 comparators
    output logic present_out,  // Partner seen
    output logic vbus_out,  // VBUS seen
    output logic [1:0] advert_out  // Advertisement seen
);
    logic [19:0] stage1_q = 20'h00000;  // Prompt comparator stage
    logic [19:0] stage2_q = 20'h00000;  // Slow settling stage
    always @(posedge clk_sys_in) begin
        stage1_q <= {lvl1_in, lvl2_in, present_in, vbus_in, advert_in};
        stage2_q <= stage1_q;
    end
    assign {line1_raw_out, line2_raw_out, present_out, vbus_out, advert_out} =
        slow_in ? stage2_q : stage1_q;
endmodule // cc_far_side
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the line match status bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys_in = 1'b0;  // 20 MHz clock
    logic rst_in = 1'b1;  // Reset
    logic [11:0] addr = 12'h000;  // Register address
    logic wr = 1'b0;  // Write strobe
    logic rd = 1'b0;  // Read strobe
    logic [15:0] wdata = 16'h0000;  // Write data
    logic [15:0] rdata;  // Read data
    logic [7:0] raw1, raw2, m1, m2;  // Comparators and match outputs
    logic [7:0] dbclr1 = 8'h00, lvl1 = 8'hFF, lvl2 = 8'hFF;  // Line settings
    logic comp_en = 1'b0, standalone = 1'b0, role = 1'b1, open = 1'b0, slow = 1'b0;
    logic present = 1'b0, vbus = 1'b0, present_w, vbus_w;  // Partner levels
    logic unit_sel = 1'b1;  // Unit select
    logic [1:0] pstate = 2'h0, adv = 2'h0, adv_w, cur_adv;  // State and advert
    int n_mismatch = 0;  // Mismatch count
    int compares = 0;  // Comparison count
    // Address beside expected read value
    logic [27:0] rows [0:6] = '{28'h803_0000, 28'h804_0000, 28'h805_0000, 28'h806_00FF,
        28'h807_00FF, 28'h808_0000, 28'h7FF_0000};
    always #25 clk_sys_in = ~clk_sys_in;
    cc_far_side u_far (.clk_sys_in(clk_sys_in), .lvl1_in(lvl1), .lvl2_in(lvl2),
        .present_in(present), .vbus_in(vbus), .advert_in(adv), .slow_in(slow),
        .line1_raw_out(raw1), .line2_raw_out(raw2), .present_out(present_w),
        .vbus_out(vbus_w), .advert_out(adv_w));
    cc_threshold_match_status #(.UNIT_LONG_CYCLES(8), .UNIT_SHORT_CYCLES(4)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .line1_raw_in(raw1),
        .line2_raw_in(raw2), .line1_dbclr_en_in(dbclr1), .line2_dbclr_en_in(8'h00),
        .comparator_enable_in(comp_en), .standalone_in(standalone), .device_role_in(role),
        .debounce_unit_select_in(unit_sel), .unattached_debounce_time_in(8'h04),
        .attached_debounce_time_in(8'h03), .port_state_in(pstate), .open_line_in(open),
        .line_present_in(present_w), .vbus_present_in(vbus_w), .advert_in(adv_w),
        .current_advert_out(cur_adv), .line1_match_out(m1), .line2_match_out(m2));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(posedge clk_sys_in);
        #1 check(rdata & mask, exp);
    endtask
    // Move the partner, read events, clear them, confirm they stay clear
    task automatic ev(input logic p, input logic v, input logic [1:0] a, input logic [15:0] e);
        @(posedge clk_sys_in);
        present <= p;
        vbus <= v;
        adv <= a;
        cyc(6);
        rd_chk(12'h803, 16'h0070, e);
        wr_reg(12'h803, 16'h0070);
        rd_chk(12'h803, 16'h0070, 16'h0000);
    endtask
    // Change line 1 in a port state, read early and after settling
    task automatic deb(input logic [1:0] st, input logic op, input logic [7:0] lv,
        input logic [7:0] e0, input logic [7:0] e1);
        @(posedge clk_sys_in);
        pstate <= st;
        open <= op;
        lvl1 <= lv;
        rd_chk(12'h806, 16'hFFFF, {8'h00, e0});
        cyc(60);
        rd_chk(12'h806, 16'hFFFF, {8'h00, e1});
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #400000;
        n_mismatch++;
        $display("Error at %0t ns: watchdog expired", $time);
        tally_and_finish;
    end
    initial begin
        cyc(8);
        rst_in <= 1'b0;
        cyc(2);
        wr_reg(12'h804, 16'h00FF);
        rd_chk(12'h804, 16'hFFFF, 16'h0000);
        wr_reg(12'h805, 16'h00FF);
        wr_reg(12'h803, 16'hFFFF);
        foreach (rows[i])
            rd_chk(rows[i][27:16], 16'hFFFF, rows[i][15:0]);
        $display("test reset values done");
        @(posedge clk_sys_in);
        comp_en <= 1'b1;
        lvl1 <= 8'h5A;
        cyc(60);
        rd_chk(12'h806, 16'hFFFF, 16'h005A);
        rd_chk(12'h804, 16'hFFFF, 16'h00A5);
        rd_chk(12'h805, 16'hFFFF, 16'h0000);
        rd_chk(12'h803, 16'hFFFF, 16'h0081);
        wr_reg(12'h803, 16'hFFFF);
        wr_reg(12'h804, 16'h000F);
        rd_chk(12'h804, 16'hFFFF, 16'h00A0);
        rd_chk(12'h803, 16'hFFFF, 16'h0001);
        wr_reg(12'h804, 16'h00F0);
        rd_chk(12'h803, 16'hFFFF, 16'h0000);
        $display("test raw mode and flags done");
        @(posedge clk_sys_in);
        dbclr1 <= 8'hFF;
        unit_sel <= 1'b0;
        deb(2'h0, 1'b0, 8'h3C, 8'h5A, 8'h3C);
        deb(2'h1, 1'b0, 8'hC3, 8'h3C, 8'h3C);
        deb(2'h1, 1'b1, 8'hC3, 8'h3C, 8'hC3);
        slow <= 1'b1;
        deb(2'h2, 1'b1, 8'h0F, 8'hC3, 8'h0F);
        $display("test debounce done");
        @(posedge clk_sys_in);
        standalone <= 1'b1;
        cyc(10);
        wr_reg(12'h803, 16'h00F0);
        ev(1'b1, 1'b0, 2'h0, 16'h0010);
        ev(1'b0, 1'b0, 2'h0, 16'h0020);
        @(posedge clk_sys_in);
        role <= 1'b0;
        cyc(10);
        wr_reg(12'h803, 16'h00F0);
        ev(1'b1, 1'b0, 2'h0, 16'h0000);
        ev(1'b1, 1'b1, 2'h0, 16'h0010);
        ev(1'b1, 1'b0, 2'h0, 16'h0020);
        ev(1'b1, 1'b0, 2'h2, 16'h0040);
        check({14'h0000, cur_adv}, 16'h0002);
        @(posedge clk_sys_in);
        standalone <= 1'b0;
        ev(1'b1, 1'b0, 2'h1, 16'h0000);
        $display("test events done");
        @(posedge clk_sys_in);
        comp_en <= 1'b0;
        rst_in <= 1'b1;
        cyc(8);
        rst_in <= 1'b0;
        cyc(2);
        rd_chk(12'h806, 16'hFFFF, 16'h0000);
        rd_chk(12'h807, 16'hFFFF, 16'h0000);
        $display("test upstream reset done");
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
